/* verilog/ldh_params.svh */
`ifndef LDH_PARAMS_SVH
`define LDH_PARAMS_SVH
// ****************************************************************
// Control word fields and sizes.
// ****************************************************************
`define LDH_BIT_RUN        4
`define LDH_BIT_NODECODE   5
`define LDH_BIT_HEXA       6
`define LDH_BIT_DATAFOLLOW 7
`define LDH_BIT_DP         7
`define LDH_DIGITS         8
`define LDH_LAST_DIGIT     3'h7
`define LDH_FIRST_DIGIT    3'h0
`define LDH_RST_CTRL       8'h90
`define LDH_RST_DATA       8'h00
`define LDH_SEG_OFF        8'h00
`define LDH_DIGIT_OFF      8'h00
`define LDH_TRI_LOW        2'h0
`define LDH_TRI_MID        2'h1
`define LDH_TRI_HIGH       2'h2
`define LDH_SCAN_DIV       16'h09C3
`define LDH_CODE_BLANK     4'hF
`endif

/* verilog/ldh_pkg.sv */
`include "ldh_params.svh"
package ldh_pkg;
   typedef logic [7:0] ldh_byte_t;
   typedef logic [2:0] ldh_addr_t;
   typedef logic [1:0] ldh_tri_t;
   typedef enum logic [1:0] {LDH_IDLE, LDH_LOADING, LDH_FULL} ldh_load_e;
endpackage : ldh_pkg

/* verilog/ldh_mem_if.sv */
interface ldh_mem_if;
   import ldh_pkg::*;
   logic      wr_en;
   ldh_addr_t wr_addr;
   ldh_byte_t wr_data;
   ldh_addr_t rd_addr;
   ldh_byte_t rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : ldh_mem_if

/* verilog/ldh_display_mem.sv */
`include "ldh_params.svh"
module ldh_display_mem (
   input  wire logic CLK_SYS,
   input  wire logic RESET,
   input  wire logic CLK_EN,
   ldh_mem_if.mem    port
);
   import ldh_pkg::*;
   ldh_byte_t mem_q [`LDH_DIGITS];
   ldh_byte_t rd_q;
   assign port.rd_data = rd_q;
   // ****************************************************************
   // Storage with registered read.
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < `LDH_DIGITS; g++) begin : g_cell
         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               mem_q[g] <= `LDH_RST_DATA;
            end else if (CLK_EN && port.wr_en && port.wr_addr == ldh_addr_t'(g)) begin
               mem_q[g] <= port.wr_data;
            end
         end
      end
   endgenerate
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rd_q <= `LDH_RST_DATA;
      end else if (CLK_EN) begin
         rd_q <= mem_q[port.rd_addr];
      end
   end
endmodule : ldh_display_mem

/* verilog/ldh_host_port.sv */
`include "ldh_params.svh"
// Function
// - Mode high with strobe low takes the bus as a control word.
// - Control word holds decode enable, decode type, shutdown and data-follows.
// - After data-follows, each strobe falling edge stores one display byte.
// - After eight loads, strobes are ignored until a new control word.
// - Sequential address advances by itself with each accepted data strobe.
// - Mode low during a strobe means the bus is display data.
// - When full, data strobes leave the device undisturbed; a control word is still taken.
// - Random variant takes settings from the three-level pin, strobe independent.
// - Random variant writes data at the presented 3-bit digit address.
// - Random write changes only the addressed digit.
// - Undecoded mode gives each of 64 bits its own output.
// - Bit4 low shutdown, bit5 low decode, bit6 high hex, bit7 data.
// - Tri pin high hex, mid alternate code, low shutdown.
// - Shutdown stops drivers and scan but writes still land.
// - Undecoded one lights a segment; decimal point lights on zero.
module ldh_host_port #(
   parameter logic [15:0] SCAN_DIV   = `LDH_SCAN_DIV,
   parameter bit          RANDOM_VAR = 1'b0
) (
   // Clock and reset.
   input  wire logic            CLK_SYS,
   input  wire logic            RESET,
   input  wire logic            CLK_EN,
   // Host bus.
   input  wire logic            WRITE_N,
   input  wire logic            MODE,
   input  wire ldh_pkg::ldh_byte_t INPUT_BUS_BITS,
   input  wire ldh_pkg::ldh_addr_t DIGIT_ADDRESS_BUS,
   input  wire ldh_pkg::ldh_tri_t  TRI_LEVEL_SETTINGS_PIN,
   // Display drive.
   output logic [7:0]           SEGMENTS,
   output logic [7:0]           DIGIT_SELECT,
   // Status.
   output logic                 SHUTDOWN,
   output logic                 LOAD_FULL
);
   import ldh_pkg::*;

   ldh_mem_if mem_bus ();

   // ****************************************************************
   // Strobe edge detect.
   // ****************************************************************
   logic      wr_prev_q;
   logic      fall;
   assign fall = wr_prev_q && !WRITE_N;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         wr_prev_q <= 1'b1;
      end else if (CLK_EN) begin
         wr_prev_q <= WRITE_N;
      end
   end

   // ****************************************************************
   // Control word register.
   // ****************************************************************
   ldh_byte_t ctrl_q;
   logic      ctrl_take;
   assign ctrl_take = !RANDOM_VAR && fall && MODE;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ctrl_q <= `LDH_RST_CTRL;
      end else if (CLK_EN && ctrl_take) begin
         ctrl_q <= INPUT_BUS_BITS;
      end
   end

   // ****************************************************************
   // Effective settings.
   // ****************************************************************
   logic eff_shut;
   logic eff_hexa;
   logic eff_decode;
   always_comb begin
      if (RANDOM_VAR) begin
         eff_shut   = TRI_LEVEL_SETTINGS_PIN == `LDH_TRI_LOW;
         eff_hexa   = TRI_LEVEL_SETTINGS_PIN == `LDH_TRI_HIGH;
         eff_decode = 1'b1;
      end else begin
         eff_shut   = !ctrl_q[`LDH_BIT_RUN];
         eff_hexa   = ctrl_q[`LDH_BIT_HEXA];
         eff_decode = !ctrl_q[`LDH_BIT_NODECODE];
      end
   end

   // ****************************************************************
   // Sequential load state.
   // ****************************************************************
   ldh_load_e state_q;
   ldh_addr_t ptr_q;
   logic      data_take;
   assign data_take = fall && !MODE && state_q == LDH_LOADING;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_q <= LDH_IDLE;
         ptr_q   <= `LDH_FIRST_DIGIT;
      end else if (CLK_EN && !RANDOM_VAR) begin
         if (ctrl_take) begin
            ptr_q   <= `LDH_FIRST_DIGIT;
            state_q <= INPUT_BUS_BITS[`LDH_BIT_DATAFOLLOW] ? LDH_LOADING : LDH_IDLE;
         end else begin
            case (state_q)
               LDH_LOADING: begin
                  if (data_take) begin
                     ptr_q <= ptr_q + 3'h1;
                     if (ptr_q == `LDH_LAST_DIGIT) begin
                        state_q <= LDH_FULL;
                     end
                  end
               end
               LDH_FULL: state_q <= LDH_FULL;
               LDH_IDLE: state_q <= LDH_IDLE;
               default:  state_q <= LDH_IDLE;
            endcase
         end
      end
   end

   // ****************************************************************
   // Memory write port.
   // ****************************************************************
   // writes continue in shutdown
   always_comb begin
      if (RANDOM_VAR) begin
         mem_bus.wr_en   = !WRITE_N;
         mem_bus.wr_addr = DIGIT_ADDRESS_BUS;
      end else begin
         mem_bus.wr_en   = data_take;
         mem_bus.wr_addr = ptr_q;
      end
      mem_bus.wr_data = INPUT_BUS_BITS;
   end

   ldh_display_mem u_mem (
      .CLK_SYS (CLK_SYS),
      .RESET   (RESET),
      .CLK_EN  (CLK_EN),
      .port    (mem_bus.mem)
   );

   // ****************************************************************
   // Scan counter.
   // ****************************************************************
   logic [15:0] div_q;
   ldh_addr_t   scan_q;
   ldh_addr_t   shown_q;
   logic        tick;
   assign tick = div_q == SCAN_DIV;
   assign mem_bus.rd_addr = scan_q;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         div_q   <= 16'h0000;
         scan_q  <= `LDH_FIRST_DIGIT;
         shown_q <= `LDH_FIRST_DIGIT;
      end else if (CLK_EN) begin
         // The shown digit follows the read address in shutdown too, so both resume aligned.
         shown_q <= scan_q;
         if (!eff_shut) begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
            if (tick) begin
               scan_q <= scan_q + 3'h1;
            end
         end
      end
   end

   // ****************************************************************
   // Segment decode.
   // ****************************************************************
   function automatic logic [6:0] seg7(input logic [3:0] v, input logic hexa);
      logic [6:0] s;
      s = 7'h00;
      case (v)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         4'hA: s = hexa ? 7'h77 : 7'h40;
         4'hB: s = hexa ? 7'h7C : 7'h79;
         4'hC: s = hexa ? 7'h39 : 7'h76;
         4'hD: s = hexa ? 7'h5E : 7'h38;
         4'hE: s = hexa ? 7'h79 : 7'h73;
         4'hF: s = hexa ? 7'h71 : 7'h00;
         default: s = 7'h00;
      endcase
      return s;
   endfunction : seg7

   ldh_byte_t seg_d;
   always_comb begin
      if (eff_decode) begin
         seg_d = {!mem_bus.rd_data[`LDH_BIT_DP], seg7(mem_bus.rd_data[3:0], eff_hexa)};
      end else begin
         seg_d = {!mem_bus.rd_data[`LDH_BIT_DP], mem_bus.rd_data[6:0]};
      end
   end

   // ****************************************************************
   // Registered outputs.
   // ****************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         SEGMENTS     <= `LDH_SEG_OFF;
         DIGIT_SELECT <= `LDH_DIGIT_OFF;
         SHUTDOWN     <= 1'b0;
         LOAD_FULL    <= 1'b0;
      end else if (CLK_EN) begin
         SHUTDOWN  <= eff_shut;
         LOAD_FULL <= state_q == LDH_FULL;
         if (eff_shut) begin
            SEGMENTS     <= `LDH_SEG_OFF;
            DIGIT_SELECT <= `LDH_DIGIT_OFF;
         end else begin
            SEGMENTS     <= seg_d;
            DIGIT_SELECT <= 8'h01 << shown_q;
         end
      end
   end
endmodule : ldh_host_port

/* testbench/ldh_host_port_monitor.sv */
`include "ldh_params.svh"
module ldh_host_port_monitor #(
   parameter bit RANDOM_VAR = 1'b0
) (
   // Host side.
   input wire logic               CLK_SYS,
   input wire logic               RESET,
   input wire logic               WRITE_N,
   input wire logic               MODE,
   input wire ldh_pkg::ldh_byte_t INPUT_BUS_BITS,
   input wire ldh_pkg::ldh_tri_t  TRI_LEVEL_SETTINGS_PIN,
   // Display side.
   input wire logic [7:0]         SEGMENTS,
   input wire logic [7:0]         DIGIT_SELECT,
   input wire logic               SHUTDOWN,
   input wire logic               LOAD_FULL
);
   timeunit 1ns / 1ps;
   import ldh_pkg::*;
   logic       wr_q;
   logic       run_q;
   logic [3:0] cnt_q;
   logic [7:0] ds_q;
   wire        ctl = wr_q && !WRITE_N && MODE;
   wire        dat = wr_q && !WRITE_N && !MODE;
   always_ff @(posedge CLK_SYS) begin
      wr_q <= RESET || WRITE_N;
      ds_q <= DIGIT_SELECT;
   end
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         cnt_q <= 4'h9;
         run_q <= 1'b1;
      end else if (ctl) begin
         cnt_q <= INPUT_BUS_BITS[7] ? 4'h0 : 4'h9;
         run_q <= INPUT_BUS_BITS[4];
      end else if (dat && cnt_q < 4'h8) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   sequence s_eighth;
      !RANDOM_VAR && dat && cnt_q == 4'h7;
   endsequence
   sequence s_quiet;
      (!RANDOM_VAR && !ctl) [*3];
   endsequence
   a_blank_in_shutdown: assert property (
      SHUTDOWN [*3] |-> {SEGMENTS, DIGIT_SELECT} == 16'h0000) else $error("drive in shutdown");
   a_digit_one_hot: assert property (
      DIGIT_SELECT != 8'h00 |-> $onehot(DIGIT_SELECT)) else $error("digit not one-hot");
   a_scan_next_digit: assert property (
      DIGIT_SELECT != ds_q && ds_q != 8'h00 && DIGIT_SELECT != 8'h00
      |-> DIGIT_SELECT == {ds_q[6:0], ds_q[7]}) else $error("scan order wrong");
   a_eighth_sets_full: assert property (
      s_eighth |-> ##[1:3] LOAD_FULL) else $error("full missing");
   a_full_holds_on: assert property (
      s_quiet ##0 LOAD_FULL |=> LOAD_FULL) else $error("full dropped");
   a_ctrl_clears_full: assert property (
      !RANDOM_VAR && ctl |-> ##[1:3] !LOAD_FULL) else $error("full kept");
   a_ctrl_sets_shutdown: assert property (
      !RANDOM_VAR && ctl |-> ##2 SHUTDOWN == !run_q) else $error("shutdown bit wrong");
   a_tri_sets_shutdown: assert property (
      (RANDOM_VAR && $stable(TRI_LEVEL_SETTINGS_PIN)) [*4]
      |-> SHUTDOWN == (TRI_LEVEL_SETTINGS_PIN == `LDH_TRI_LOW)) else $error("tri wrong");
endmodule : ldh_host_port_monitor
bind ldh_host_port ldh_host_port_monitor #(.RANDOM_VAR(RANDOM_VAR)) mon (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .WRITE_N(WRITE_N), .MODE(MODE),
   .INPUT_BUS_BITS(INPUT_BUS_BITS), .TRI_LEVEL_SETTINGS_PIN(TRI_LEVEL_SETTINGS_PIN),
   .SEGMENTS(SEGMENTS), .DIGIT_SELECT(DIGIT_SELECT), .SHUTDOWN(SHUTDOWN),
   .LOAD_FULL(LOAD_FULL));

/* testbench/ldh_host_model.sv */
module ldh_host_model (
   // Host bus.
   input  wire logic          clk_sys,
   output ldh_pkg::ldh_byte_t bus,
   output ldh_pkg::ldh_addr_t addr,
   output logic               write_n,
   output logic               mode
);
   timeunit 1ns / 1ps;
   import ldh_pkg::*;
   initial begin
      bus     = 8'h00;
      addr    = 3'h0;
      write_n = 1'b1;
      mode    = 1'b0;
   end
   task automatic wr(input logic m, input ldh_byte_t d, input ldh_addr_t a);
      @(negedge clk_sys);
      mode    = m;
      bus     = d;
      addr    = a;
      write_n = 1'b0;
      @(negedge clk_sys);
      write_n = 1'b1;
      bus     = ~d;
      addr    = ~a;
   endtask : wr
endmodule : ldh_host_model

/* testbench/led_display_host_write_port_tb_top.sv */
`include "ldh_params.svh"
module led_display_host_write_port_tb_top;
   timeunit 1ns / 1ps;
   import ldh_pkg::*;
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   ldh_tri_t    tri_pin = `LDH_TRI_MID;
   ldh_byte_t   bus;
   ldh_addr_t   addr;
   logic        write_n;
   logic        mode;
   logic [7:0]  seg [2];
   logic [7:0]  ds [2];
   logic [7:0]  pds [2];
   logic        sd [2];
   logic        full [2];
   int          st [2];
   logic [7:0]  img [8];
   logic [6:0]  hex_hi [8] = '{7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
   logic [11:0] notes [$];
   int          err_count = 0;
   int          compares  = 0;
   int          seed      = 60;
   initial begin
      forever #20 clk = ~clk;
   end
   ldh_host_model m (.clk_sys(clk), .bus(bus), .addr(addr), .write_n(write_n), .mode(mode));
   for (genvar i = 0; i < 2; i++) begin : g_dut
      ldh_host_port #(.SCAN_DIV(16'h0003), .RANDOM_VAR(i == 1)) uut (
         .CLK_SYS(clk), .RESET(rst), .CLK_EN(1'b1), .WRITE_N(write_n), .MODE(mode),
         .INPUT_BUS_BITS(bus), .DIGIT_ADDRESS_BUS(addr), .TRI_LEVEL_SETTINGS_PIN(tri_pin),
         .SEGMENTS(seg[i]), .DIGIT_SELECT(ds[i]), .SHUTDOWN(sd[i]), .LOAD_FULL(full[i]));
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic show(input logic inst);
      for (int n = 0; n < 8; n++) begin
         notes.push_back({inst, n[2:0], img[n]});
      end
      repeat (300) begin
         if (notes.size() != 0) @(negedge clk);
      end
      check("digits shown", notes.size(), 0);
   endtask : show
   task automatic load(input ldh_byte_t ctl);
      ldh_byte_t b;
      // Control word, then all eight bytes.
      m.wr(1'b1, ctl, 3'h0);
      for (int n = 0; n < 8; n++) begin
         b = 8'($random(seed));
         m.wr(1'b0, b, 3'h0);
         img[n] = {~b[7], b[6:0]};
      end
   endtask : load
   always @(negedge clk) begin
      for (int i = 0; i < 2; i++) begin
         st[i] = (ds[i] === pds[i]) ? st[i] + 1 : 0;
         pds[i] = ds[i];
         if (st[i] == 2 && notes.size() > 0 && notes[0][11] == i
             && ds[i] === 8'h01 << notes[0][10:8]) begin
            check("SEGMENTS", seg[i], notes[0][7:0]);
            void'(notes.pop_front());
         end
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("SHUTDOWN", sd[0], 1'b0);
      check("LOAD_FULL", full[0], 1'b0);
      $display("test reset done");
      load(8'hB0);
      repeat (3) @(negedge clk);
      check("LOAD_FULL", full[0], 1'b1);
      show(1'b0);
      repeat (8) m.wr(1'b0, 8'($random(seed)), 3'h0);
      check("LOAD_FULL", full[0], 1'b1);
      show(1'b0);
      $display("test load done");
      m.wr(1'b1, 8'hA0, 3'h0);
      repeat (3) m.wr(1'b0, 8'h55, 3'h0);
      check("LOAD_FULL", full[0], 1'b0);
      load(8'hA0);
      repeat (3) @(negedge clk);
      check("SHUTDOWN", sd[0], 1'b1);
      check("DIGIT_SELECT", ds[0], 8'h00);
      check("LOAD_FULL", full[0], 1'b1);
      m.wr(1'b1, 8'h30, 3'h0);
      m.wr(1'b0, 8'h55, 3'h0);
      show(1'b0);
      $display("test shutdown done");
      // Hexadecimal decode of the codes 8 to F.
      m.wr(1'b1, 8'hD0, 3'h0);
      for (int n = 0; n < 8; n++) begin
         m.wr(1'b0, {4'h0, 4'(n + 8)}, 3'h0);
         img[n] = {1'b1, hex_hi[n]};
      end
      show(1'b0);
      $display("test decode done");
      for (int n = 0; n < 8; n++) begin
         m.wr(1'b0, 8'h8F, n[2:0]);
         img[n] = 8'h00;
      end
      m.wr(1'b0, 8'h0F, 3'h7);
      img[7] = 8'h80;
      show(1'b1);
      tri_pin = `LDH_TRI_LOW;
      repeat (4) @(negedge clk);
      check("SHUTDOWN", sd[1], 1'b1);
      tri_pin = `LDH_TRI_HIGH;
      repeat (4) @(negedge clk);
      check("SHUTDOWN", sd[1], 1'b0);
      // High pin level selects hexadecimal decoding.
      for (int n = 0; n < 8; n++) begin
         img[n] = (n == 7) ? 8'hF1 : 8'h71;
      end
      show(1'b1);
      $display("test random done");
      print_verdict();
   end
   initial begin
      #400000;
      err_count++;
      print_verdict();
   end
endmodule : led_display_host_write_port_tb_top
